// File: core/can_timing_mask_irq_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// (R01) prescaler is code plus two, max 128
// (R02) jump width is code plus one quanta
// (R03) software keeps jump width within both segments
// (R04) segment one is code plus one quanta
// (R05) segment two is code plus one quanta
// (R06) mask zero must match, one ignores
// (R07) ignored bits take received value on accept
// (R08) extended frames use all mask bits
// (R09) standard frames use id 28:18, rtr, ide
// (R10) buffer 14 uses the basic mask
// (R11) basic mask follows the same frame rules
// (R12) each mask is two sixteen bit halves
// (R13) enable: bit 15 error, 14:0 buffers
// (R14) error irq only when error enable set
// (R15) error pending set on error event chosen by type bit, sticky
// (R16) buffer pending set after successful transfer
// (R17) software clears error pending via clear register
// (R18) clear bit 15 one clears error pending
// (R19) clear bit n one clears buffer pending
// (R20) clear register takes plain writes only
// (R21) error type selects every error or state change
// (R22) disable clears internal state, keeps registers
// (R23) bit is sync, segment one, segment two
// (R24) registers reset to zero
module can_timing_mask_irq_regs
	import can_cfg_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [14:0] bufDone,       // per buffer transfer success
	input  wire logic        busError,      // any bus error seen
	input  wire logic        errStateChange, // counter step moved node state
	input  wire logic        frameValid,    // compare request for a frame
	input  wire logic [3:0]  bufIndex,      // buffer being compared
	input  wire logic        extFrame,      // frame is extended
	input  wire logic [31:0] rxIdWord,      // received id in mask layout
	input  wire logic [31:0] bufIdWord,     // buffer id in mask layout
	output logic             acceptHit,     // frame matches buffer
	output logic [31:0]      acceptIdWord,  // id to store in buffer
	output logic             errorIrq,      // error interrupt to processor
	output logic [14:0]      bufferIrq,     // enabled buffer interrupts
	output logic             moduleRun,     // module enabled
	output logic [1:0]       clkResetUnused, // reserved, reads zero
	output logic [2:0]       resyncJumpWidth, // quanta of jump width
	output logic             quantumTick,   // one pulse per quantum
	output logic             bitStart       // pulse at each bit start
);
	typedef struct packed {
		logic [15:0] timing;
		logic [15:0] gUp;
		logic [15:0] gLo;
		logic [15:0] bUp;
		logic [15:0] bLo;
		logic [15:0] buffer_irq_enables;
		logic [15:0] pend;
		logic [15:0] gcfg;
		logic [31:0] rdata;
		logic        hit;
		logic [31:0] merged;
	} regs_t;
	regs_t       r_reg;       // registered state
	regs_t       r_next;      // next state
	logic        wrAcc;       // write access phase
	logic        rdAcc;       // read access phase
	logic        mapped;      // address decodes to a register
	logic [15:0] clrMask;     // bits cleared by this write
	logic [15:0] setMask;     // bits set by hardware this cycle
	logic        errEvent;    // error event chosen by type bit
	logic [7:0]  prescale;    // decoded prescaler
	logic [7:0]  pscRaw;      // code plus two before clamp
	accept_if    acc ();      // filter connection
	////////////////////////////////////////////////////////////////////////
	// bus decode
	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	always_comb begin
		if (paddr == OFS_TIMING) begin
			mapped = 1'b1;
		end else if (paddr == OFS_GMASK_UP || paddr == OFS_GMASK_LO) begin
			mapped = 1'b1;
		end else if (paddr == OFS_BMASK_UP || paddr == OFS_BMASK_LO) begin
			mapped = 1'b1;
		end else if (paddr == OFS_IRQ_EN || paddr == OFS_IRQ_PEND) begin
			mapped = 1'b1;
		end else if (paddr == OFS_IRQ_CLR || paddr == OFS_GLOBAL_CFG) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	////////////////////////////////////////////////////////////////////////
	// interrupt event selection
	always_comb begin
		// type bit chooses every error or state change only [R21]
		errEvent = r_reg.gcfg[EIT_BIT] ? errStateChange : busError;
		setMask = {errEvent && r_reg.gcfg[MODEN_BIT], bufDone}; // [R15] [R16]
		// one bits clear, zero bits leave alone [R18] [R19]
		clrMask = (wrAcc && paddr == OFS_IRQ_CLR) ? pwdata[15:0] : 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	// register file and read mux
	always_comb begin
		r_next = r_reg;
		// set wins over a clear in the same cycle [R15] [R16] [R17]
		r_next.pend = (r_reg.pend & ~clrMask) | setMask;
		if (wrAcc) begin
			if (paddr == OFS_TIMING) begin
				r_next.timing = pwdata[15:0];
			end else if (paddr == OFS_GMASK_UP) begin
				r_next.gUp = pwdata[15:0]; // [R12]
			end else if (paddr == OFS_GMASK_LO) begin
				r_next.gLo = pwdata[15:0]; // [R12]
			end else if (paddr == OFS_BMASK_UP) begin
				r_next.bUp = pwdata[15:0];
			end else if (paddr == OFS_BMASK_LO) begin
				r_next.bLo = pwdata[15:0];
			end else if (paddr == OFS_IRQ_EN) begin
				r_next.buffer_irq_enables = pwdata[15:0]; // [R13]
			end else if (paddr == OFS_GLOBAL_CFG) begin
				r_next.gcfg = pwdata[15:0];
			end else begin
				r_next.gcfg = r_reg.gcfg; // pending is read only
			end
		end
		// read data, clear register reads zero
		r_next.rdata = 32'h00000000;
		if (rdAcc) begin
			if (paddr == OFS_TIMING) begin
				r_next.rdata = {16'h0000, r_reg.timing};
			end else if (paddr == OFS_GMASK_UP) begin
				r_next.rdata = {16'h0000, r_reg.gUp};
			end else if (paddr == OFS_GMASK_LO) begin
				r_next.rdata = {16'h0000, r_reg.gLo};
			end else if (paddr == OFS_BMASK_UP) begin
				r_next.rdata = {16'h0000, r_reg.bUp};
			end else if (paddr == OFS_BMASK_LO) begin
				r_next.rdata = {16'h0000, r_reg.bLo};
			end else if (paddr == OFS_IRQ_EN) begin
				r_next.rdata = {16'h0000, r_reg.buffer_irq_enables};
			end else if (paddr == OFS_IRQ_PEND) begin
				r_next.rdata = {16'h0000, r_reg.pend};
			end else if (paddr == OFS_GLOBAL_CFG) begin
				r_next.rdata = {16'h0000, r_reg.gcfg};
			end else begin
				r_next.rdata = 32'h00000000;
			end
		end
		// acceptance result registered
		r_next.hit = frameValid && acc.hit;
		r_next.merged = frameValid ? acc.mergedWord : r_reg.merged;
	end
	////////////////////////////////////////////////////////////////////////
	// state register, all zero at reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '0; // [R24]
		end else begin
			r_reg <= r_next;
		end
	end
	// read data is not registered: it appears combinationally from the mux
	assign prdata = rdAcc ? r_next.rdata : 32'h00000000;
	////////////////////////////////////////////////////////////////////////
	// acceptance filter: buffer 14 uses the basic mask
	always_comb begin
		acc.maskWord = (bufIndex == BASIC_BUF) // [R10] [R11]
			? {r_reg.bUp, r_reg.bLo} : {r_reg.gUp, r_reg.gLo}; // [R12]
		acc.rxWord = rxIdWord;
		acc.bufWord = bufIdWord;
		acc.extFrame = extFrame;
	end
	accept_filter u_filter (
		.port (acc.filter)
	);
	assign acceptHit = r_reg.hit;
	assign acceptIdWord = r_reg.merged;
	////////////////////////////////////////////////////////////////////////
	// timing decode
	always_comb begin
		pscRaw = {1'b0, r_reg.timing[PSC_LSB +: 7]} + PSC_ADD; // [R01]
		prescale = (pscRaw > PSC_MAX) ? PSC_MAX : pscRaw; // [R01]
		resyncJumpWidth = {1'b0, r_reg.timing[SJW_LSB +: 2]} + 3'h1; // [R02]
	end
	bit_timing u_timing (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.runEn       (r_reg.gcfg[MODEN_BIT]), // [R22]
		.prescale    (prescale),
		.segOneTq    ({1'b0, r_reg.timing[TS1_LSB +: 4]} + 5'h01), // [R04]
		.segTwoTq    ({1'b0, r_reg.timing[TS2_LSB +: 3]} + 4'h1), // [R05]
		.quantumTick (quantumTick),
		.bitStart    (bitStart)
	);
	////////////////////////////////////////////////////////////////////////
	// interrupt outputs gated by enables
	assign errorIrq = r_reg.pend[ERR_BIT] && r_reg.buffer_irq_enables[ERR_BIT]; // [R14]
	assign bufferIrq = r_reg.pend[14:0] & r_reg.buffer_irq_enables[14:0]; // [R13]
	assign moduleRun = r_reg.gcfg[MODEN_BIT];
	assign clkResetUnused = 2'b00;
	////////////////////////////////////////////////////////////////////////
	// checks
	AST_ERR_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!r_reg.buffer_irq_enables[ERR_BIT] |-> !errorIrq) // [R14]
		else $error("error irq raised while disabled");
	AST_ERR_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		r_reg.pend[ERR_BIT] && !(wrAcc && paddr == OFS_IRQ_CLR
		&& pwdata[ERR_BIT]) |=> r_reg.pend[ERR_BIT]) // [R15]
		else $error("error pending dropped without clear");
	AST_BUF_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
		bufDone[0] |=> r_reg.pend[0]) // [R16]
		else $error("buffer pending not set");
	AST_ERR_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		wrAcc && paddr == OFS_IRQ_CLR && pwdata[ERR_BIT] && !setMask[ERR_BIT]
		|=> !r_reg.pend[ERR_BIT]) // [R18]
		else $error("error pending not cleared");
	AST_BUF_ZERO_KEEP: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		wrAcc && paddr == OFS_IRQ_CLR && !pwdata[3] && r_reg.pend[3]
		|=> r_reg.pend[3]) // [R19]
		else $error("zero write cleared a pending bit");
	AST_PSC_CLAMP: assert property (@(posedge sys_clk) disable iff (!reset_n)
		r_reg.timing[15:9] == 7'h7f |-> prescale == 8'h80) // [R01]
		else $error("prescaler clamp wrong");
	AST_SJW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		resyncJumpWidth == r_reg.timing[8:7] + 3'h1) // [R02]
		else $error("jump width wrong");
	AST_EIT_TYPE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		r_reg.gcfg[EIT_BIT] && r_reg.gcfg[0] && !errStateChange && busError
		&& !r_reg.pend[ERR_BIT] |=> !r_reg.pend[ERR_BIT]) // [R21]
		else $error("error flag set by plain error in state mode");
	AST_STD_IGNORE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		frameValid && !extFrame && bufIndex != 4'he
		&& (rxIdWord[31:21] == bufIdWord[31:21] || &r_reg.gUp[15:5])
		&& (rxIdWord[20:19] == bufIdWord[20:19] || &r_reg.gUp[4:3])
		|=> acceptHit) // [R09]
		else $error("standard frame compared beyond id bits");
endmodule : can_timing_mask_irq_regs

// File: shared/can_cfg_pkg.sv
package can_cfg_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_TIMING = 8'h00;
	localparam logic [7:0] OFS_GMASK_UP = 8'h04;
	localparam logic [7:0] OFS_GMASK_LO = 8'h08;
	localparam logic [7:0] OFS_BMASK_UP = 8'h0c;
	localparam logic [7:0] OFS_BMASK_LO = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;
	localparam logic [7:0] OFS_IRQ_PEND = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
	localparam logic [7:0] OFS_GLOBAL_CFG = 8'h20;
	// timing register field positions
	localparam int PSC_LSB = 9;
	localparam int SJW_LSB = 7;
	localparam int TS1_LSB = 3;
	localparam int TS2_LSB = 0;
	// global config bit positions
	localparam int MODEN_BIT = 0;
	localparam int EIT_BIT = 11;
	// interrupt register layout
	localparam int ERR_BIT = 15;
	localparam int NUM_BUF = 15;
	// mask upper register layout
	localparam int MU_RTR_BIT = 4;
	localparam int MU_IDE_BIT = 3;
	// reset values
	localparam logic [15:0] REG_RESET = 16'h0000;
	// prescaler limits
	localparam logic [7:0] PSC_MAX = 8'h80;
	localparam logic [7:0] PSC_ADD = 8'h02;
	// buffer that uses the basic mask
	localparam logic [3:0] BASIC_BUF = 4'he;
endpackage : can_cfg_pkg

// File: shared/accept_if.sv
`timescale 1ns/100ps
// one acceptance compare: mask, frame and buffer identifier in, result out
interface accept_if;
	logic [31:0] maskWord;   // upper and lower mask halves joined
	logic [31:0] rxWord;     // received frame in mask layout
	logic [31:0] bufWord;    // buffer identifier in mask layout
	logic        extFrame;   // frame is extended
	logic        hit;        // frame accepted
	logic [31:0] mergedWord; // buffer word after don't care substitution
	modport owner (output maskWord, rxWord, bufWord, extFrame,
		input hit, mergedWord);
	modport filter (input maskWord, rxWord, bufWord, extFrame,
		output hit, mergedWord);
endinterface : accept_if

// File: core/accept_filter.sv
`timescale 1ns/100ps
module accept_filter
	import can_cfg_pkg::*;
(
	accept_if.filter port
);
	logic [31:0] used; // mask positions that take part for this frame type
	logic [31:0] care; // positions that must match
	////////////////////////////////////////////////////////////////////////
	// combinational compare and merge
	always_comb begin
		// standard frames use only id 28:18, rtr and ide [R09] [R11]
		used = port.extFrame ? 32'hffffffff : 32'hfff80000; // [R08]
		care = used & ~port.maskWord; // zero mask bit means must match [R06]
		port.hit = ((port.rxWord ^ port.bufWord) & care) == 32'h00000000;
		// don't care positions take the received bit [R07]
		port.mergedWord = (port.bufWord & ~(used & port.maskWord))
			| (port.rxWord & used & port.maskWord);
	end
endmodule : accept_filter

// File: core/bit_timing.sv
`timescale 1ns/100ps
module bit_timing
	import can_cfg_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       runEn,      // module enabled
	input  wire logic [7:0] prescale,   // clocks per quantum
	input  wire logic [4:0] segOneTq,   // quanta in segment one
	input  wire logic [3:0] segTwoTq,   // quanta in segment two
	output logic            quantumTick, // one pulse per quantum
	output logic            bitStart    // sync quantum pulse
);
	typedef enum logic [1:0] {SEG_SYNC, SEG_ONE, SEG_TWO} seg_t;
	typedef struct packed {
		logic [7:0] clkCnt;
		logic [4:0] tqCnt;
		seg_t       seg;
		logic       tick;
		logic       start;
	} bt_state_t;
	bt_state_t st_reg; // registered state
	bt_state_t st_next; // next state
	logic endQ; // last clock of a quantum
	////////////////////////////////////////////////////////////////////////
	// quantum and segment sequencing
	always_comb begin
		st_next = st_reg;
		endQ = st_reg.clkCnt == prescale - 8'h01; // [R23]
		st_next.tick = 1'b0;
		st_next.start = 1'b0;
		if (!runEn) begin
			// disabled: internal state cleared [R22]
			st_next = '0;
		end else if (endQ) begin
			st_next.clkCnt = 8'h00;
			st_next.tick = 1'b1;
			case (st_reg.seg)
				SEG_SYNC: begin
					st_next.seg = SEG_ONE;
					st_next.tqCnt = 5'h01;
				end
				SEG_ONE: begin
					if (st_reg.tqCnt >= segOneTq) begin
						st_next.seg = SEG_TWO;
						st_next.tqCnt = 5'h01;
					end else begin
						st_next.tqCnt = st_reg.tqCnt + 5'h01;
					end
				end
				default: begin
					if (st_reg.tqCnt >= {1'b0, segTwoTq}) begin
						st_next.seg = SEG_SYNC; // [R23]
						st_next.start = 1'b1;
					end else begin
						st_next.tqCnt = st_reg.tqCnt + 5'h01;
					end
				end
			endcase
		end else begin
			st_next.clkCnt = st_reg.clkCnt + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign quantumTick = st_reg.tick;
	assign bitStart = st_reg.start;
	AST_QUANTUM_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st_reg.tick && runEn && !$changed(prescale) |-> st_reg.clkCnt == 8'h00
		|| prescale == 8'h01) // [R23]
		else $error("quantum counter did not restart");
endmodule : bit_timing

// File: verif/can_far_side.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// far side model: buffer events, error events and frame compares
module can_far_side (
	input  wire logic sys_clk,
	output logic [14:0] bufDone,
	output logic        busError,
	output logic        errStateChange,
	output logic        frameValid,
	output logic [3:0]  bufIndex,
	output logic        extFrame,
	output logic [31:0] rxIdWord,
	output logic [31:0] bufIdWord
);
	// quiet state at time zero
	initial begin
		bufDone = 15'h0;
		busError = 1'h0;
		errStateChange = 1'h0;
		frameValid = 1'h0;
		bufIndex = 4'h0;
		extFrame = 1'h0;
		rxIdWord = 32'h0;
		bufIdWord = 32'h0;
	end
	// one-cycle event pulses
	task automatic events(input logic [14:0] d, input logic be,
		input logic sc);
		@(posedge sys_clk);
		bufDone <= d;
		busError <= be;
		errStateChange <= sc;
		@(posedge sys_clk);
		bufDone <= 15'h0;
		busError <= 1'h0;
		errStateChange <= 1'h0;
	endtask : events
	// one compare request; words turn stale once taken
	task automatic frame(input logic [3:0] i, input logic e,
		input logic [31:0] r, input logic [31:0] b);
		@(posedge sys_clk);
		frameValid <= 1'h1;
		bufIndex <= i;
		extFrame <= e;
		rxIdWord <= r;
		bufIdWord <= b;
		@(posedge sys_clk);
		frameValid <= 1'h0;
		rxIdWord <= ~r;
		bufIdWord <= ~b;
	endtask : frame
endmodule : can_far_side

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	import can_cfg_pkg::*;
	logic        sys_clk, reset_n, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rxIdWord, bufIdWord, acceptIdWord;
	logic        pready, pslverr, busError, errStateChange;
	logic        frameValid, extFrame, acceptHit, errorIrq, moduleRun;
	logic [14:0] bufDone, bufferIrq;
	logic [3:0]  bufIndex;
	logic [1:0]  clkResetUnused;
	logic [2:0]  resyncJumpWidth;
	logic        quantumTick, bitStart;
	int          errors, checks;
	can_timing_mask_irq_regs dut (.*);
	can_far_side far (.*);
	////////////////////////////////////////////////////////////////
	// clock at 40 MHz
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// verdict
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			errors++;
			complete_run();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
		// let the write settle before outputs are looked at
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		chk(r, x);
	endtask : rd
	// cycles between two pulses of a sequencer output
	task automatic period(input logic b, output int n);
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			#1 k++;
		end while ((b ? bitStart : quantumTick) !== 1'h1 && k < 4000);
		if (k >= 4000) begin
			errors++;
			complete_run();
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while ((b ? bitStart : quantumTick) !== 1'h1 && n < 4000);
		if (n >= 4000) begin
			errors++;
			complete_run();
		end
	endtask : period
	////////////////////////////////////////////////////////////////
	// reset contents and unmapped access
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
		apb(1'h0, 8'h40, 32'h0, r, e);
		chk(32'(e), 32'h1);
		chk(32'(clkResetUnused), 32'h0);
		chk(32'(moduleRun), 32'h0);
		$display("done reset");
	endtask : t_reset
	// quantum and bit lengths per timing code
	task automatic t_timing;
		int c[3][4] = '{'{0, 1, 1, 1}, '{126, 0, 1, 0}, '{127, 3, 15, 7}};
		int n, p, q;
		for (int i = 0; i < 3; i++) begin
			wr(OFS_GLOBAL_CFG, 32'h0);
			// jump width never above either segment
			wr(OFS_TIMING, 32'(c[i][0] << PSC_LSB | c[i][1] << SJW_LSB
				| c[i][2] << TS1_LSB | c[i][3]));
			wr(OFS_GLOBAL_CFG, 32'h1);
			chk(32'(resyncJumpWidth), 32'(c[i][1] + 1));
			chk(32'(moduleRun), 32'h1);
			p = (c[i][0] == 127) ? 128 : c[i][0] + 2;
			q = 3 + c[i][2] + c[i][3];
			period(1'h0, n);
			chk(32'(n), 32'(p));
			period(1'h1, n);
			chk(32'(n), 32'(p * q));
		end
		wr(OFS_GLOBAL_CFG, 32'h0);
		n = 0;
		repeat (300) begin
			@(posedge sys_clk);
			#1 n += quantumTick;
		end
		chk(32'(n), 32'h0);
		rd(OFS_TIMING, 32'hffff);
		$display("done timing");
	endtask : t_timing
	// buffer pending, enables and clears
	task automatic t_irq;
		wr(OFS_GLOBAL_CFG, 32'h1);
		wr(OFS_IRQ_EN, 32'h4001);
		far.events(15'h4001, 1'h0, 1'h0);
		rd(OFS_IRQ_PEND, 32'h4001);
		chk(32'(bufferIrq), 32'h4001);
		wr(OFS_IRQ_PEND, 32'h0);
		rd(OFS_IRQ_PEND, 32'h4001);
		wr(OFS_IRQ_CLR, 32'h1);
		rd(OFS_IRQ_PEND, 32'h4000);
		wr(OFS_IRQ_CLR, 32'h0);
		rd(OFS_IRQ_PEND, 32'h4000);
		wr(OFS_IRQ_EN, 32'h0);
		chk(32'(bufferIrq), 32'h0);
		wr(OFS_IRQ_CLR, 32'h4000);
		rd(OFS_IRQ_PEND, 32'h0);
		$display("done irq");
	endtask : t_irq
	// error pending under both error types
	task automatic t_error;
		far.events(15'h0, 1'h1, 1'h0);
		rd(OFS_IRQ_PEND, 32'h8000);
		chk(32'(errorIrq), 32'h0);
		wr(OFS_IRQ_EN, 32'h8000);
		chk(32'(errorIrq), 32'h1);
		wr(OFS_IRQ_CLR, 32'h0);
		rd(OFS_IRQ_PEND, 32'h8000);
		wr(OFS_IRQ_CLR, 32'h8000);
		rd(OFS_IRQ_PEND, 32'h0);
		wr(OFS_GLOBAL_CFG, 32'h1 | 32'h1 << EIT_BIT);
		far.events(15'h0, 1'h1, 1'h0);
		rd(OFS_IRQ_PEND, 32'h0);
		far.events(15'h0, 1'h0, 1'h1);
		rd(OFS_IRQ_PEND, 32'h8000);
		chk(32'(errorIrq), 32'h1);
		$display("done error");
	endtask : t_error
	// acceptance compares against global and basic masks
	task automatic t_filter;
		logic [31:0] f[7] = '{32'h80000000, 32'h80000000, 32'h2,
			32'h2, 32'h2, 32'h1, 32'h80000};
		logic [3:0]  x[7] = '{3, 14, 14, 3, 3, 3, 3};
		logic        e[7] = '{1, 1, 1, 1, 0, 1, 0};
		logic        h[7] = '{1, 0, 1, 0, 1, 0, 0};
		logic [31:0] b, m;
		b = 32'h12345678;
		wr(OFS_GMASK_UP, 32'hffe0);
		wr(OFS_GMASK_LO, 32'h0);
		wr(OFS_BMASK_UP, 32'h0);
		wr(OFS_BMASK_LO, 32'h2);
		rd(OFS_GMASK_UP, 32'hffe0);
		for (int i = 0; i < 7; i++) begin
			m = (x[i] == BASIC_BUF) ? 32'h2 : 32'hffe00000;
			far.frame(x[i], e[i], b ^ f[i], b);
			#1 chk(32'(acceptHit), 32'(h[i]));
			if (h[i] && e[i])
				chk(acceptIdWord, (b & ~m) | ((b ^ f[i]) & m));
		end
		$display("done filter");
	endtask : t_filter
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		errors = 0;
		checks = 0;
		reset_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'h1;
		t_reset();
		t_timing();
		t_irq();
		t_error();
		t_filter();
		complete_run();
	end
endmodule : testbench
